// ===== hdl/gpc_pkg.sv
/*
 * Shared constants of the GPIO port with change notification:
 * register offsets, widths, reset values, field positions and settle counts.
 * Assumes a 32-bit APB register bus with byte addresses on paddr.
 */
package gpc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int GPC_DATA_W = 32;
    localparam int GPC_ADDR_W = 8;
    localparam int GPC_HALF_W = 16;

    // ==========================================================
    // Register byte offsets
    localparam logic [GPC_ADDR_W-1:0] OFS_PIN_DIRECTION = 8'h00;
    localparam logic [GPC_ADDR_W-1:0] OFS_OUTPUT_LATCH = 8'h04;
    localparam logic [GPC_ADDR_W-1:0] OFS_PIN_LEVEL = 8'h08;
    localparam logic [GPC_ADDR_W-1:0] OFS_OPEN_DRAIN = 8'h0c;
    localparam logic [GPC_ADDR_W-1:0] OFS_ANALOG_CFG = 8'h10;
    localparam logic [GPC_ADDR_W-1:0] OFS_CN_ENABLE_LO = 8'h14;
    localparam logic [GPC_ADDR_W-1:0] OFS_CN_ENABLE_HI = 8'h18;
    localparam logic [GPC_ADDR_W-1:0] OFS_PULLUP_LO = 8'h1c;
    localparam logic [GPC_ADDR_W-1:0] OFS_PULLUP_HI = 8'h20;
    localparam logic [GPC_ADDR_W-1:0] OFS_CN_STATUS = 8'h24;

    // ==========================================================
    // Sizes and defaults
    localparam int GPC_PINS_MAX = 16;
    localparam int GPC_CN_MAX = 31;
    localparam logic [GPC_HALF_W-1:0] GPC_IMPL_DFLT = 16'hffff;
    localparam logic [GPC_HALF_W-1:0] GPC_ANCAP_DFLT = 16'h003f;

    // ==========================================================
    // Reset values
    localparam logic [GPC_HALF_W-1:0] DIR_RST = 16'hffff;
    localparam logic [GPC_HALF_W-1:0] LATCH_RST = 16'h0000;
    localparam logic [GPC_HALF_W-1:0] ODC_RST = 16'h0000;
    localparam logic [GPC_HALF_W-1:0] ANCFG_RST = 16'h0000;
    localparam logic [GPC_HALF_W-1:0] CNEN_RST = 16'h0000;
    localparam logic [GPC_HALF_W-1:0] CNPU_RST = 16'h0000;

    // ==========================================================
    // Status fields and timing
    localparam int CN_PEND_BIT = 0;
    localparam logic [2:0] CN_SETTLE_CYC = 3'h5;

endpackage

// ===== hdl/gpc_cn_if.sv
/*
 * Link between the port core and the change-notify detector.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none

interface gpc_cn_if #(parameter int N = 31);
    logic [N-1:0] raw;
    logic [N-1:0] enable;
    logic clear;
    logic pending;
    logic wake;
    logic [N-1:0] level;

    // ==========================================================
    // Port core side
    modport ctrl (output raw, output enable, output clear,
                  input pending, input wake, input level);
    // Detector side
    modport det (input raw, input enable, input clear,
                 output pending, output wake, output level);
endinterface

`default_nettype wire

// ===== hdl/gpc_cn_detect.sv
/*
 * Change-notify detector: synchronises the notify inputs, compares each
 * with its last recorded level and keeps one sticky pending flag.
 * Assumes raw inputs are asynchronous pins and clear is a pclk pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module gpc_cn_detect #(
    parameter int N = 31
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link to the port core
    gpc_cn_if.det cn
);
    import gpc_pkg::*;

    // ==========================================================
    // Elaboration checks; enables and pull-ups span only two half words
    generate
        if (N < 1 || N > GPC_CN_MAX)
        begin : g_bad_n
            $error("N out of range");
        end
    endgenerate

    logic [N-1:0] s1_r;
    logic [N-1:0] s2_r;
    logic [N-1:0] s3_r;
    logic [N-1:0] filt_r;
    logic [N-1:0] last_r;
    logic [2:0] settle_r;
    logic pending_r;
    logic settled;
    logic [N-1:0] change;

    // ==========================================================
    // Synchroniser chain; s1 feeds only s2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= cn.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Filtered level moves only where stages two and three agree
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_filt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    filt_r[g] <= 1'b0;
                else if (s2_r[g] == s3_r[g])
                    filt_r[g] <= s3_r[g];
            end
        end
    endgenerate

    // Last recorded level, one cycle behind the filtered one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_r <= '0;
        else
            last_r <= filt_r;
    end

    // Settle counter hides the fill of the chain after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            settle_r <= '0;
        else if (!settled)
            settle_r <= settle_r + 3'h1;
    end
    assign settled = (settle_r == CN_SETTLE_CYC);

    // Only enabled inputs may compare
    assign change = cn.enable & (filt_r ^ last_r) & {N{settled}};

    // Sticky flag; a new change beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending_r <= 1'b0;
        else if (|change)
            pending_r <= 1'b1;
        else if (cn.clear)
            pending_r <= 1'b0;
    end

    // Clockless wake: raw pin against last filtered level, may glitch
    assign cn.wake = |(cn.enable & (cn.raw ^ filt_r));
    assign cn.pending = pending_r;
    assign cn.level = filt_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cn_sets_flag: assert property (|change |=> pending_r)
        else $error("enabled change did not set pending");
    a_cn_only_enabled: assert property ($rose(pending_r) |->
        $past(|(cn.enable & (filt_r ^ last_r))))
        else $error("pending rose without an enabled change");
    a_cn_sticky: assert property (pending_r && !cn.clear |=> pending_r)
        else $error("pending dropped without a clear");
    a_cn_clears: assert property (cn.clear && !(|change) |=> !pending_r)
        else $error("clear did not drop pending");

endmodule

`default_nettype wire

// ===== hdl/gpc_port.sv
/*
 * GPIO port with per-pin direction, output latch, pin read path,
 * open-drain select, analog configuration, pull-ups and change notify.
 * Assumes an APB master on pclk, asynchronous pins and peripherals whose
 * enable/drive/output signals are on pclk.
 */
// Chosen here: register access over APB and the register addresses.
// Summary of operation
// - Driving peripheral owns pin; level stays readable
// - Idle peripheral leaves pin to port
// - Port output never loops into peripheral
// - Direction one is input, zero output
// - Reset makes every pin an input
// - Latch reads latch, writes latch only
// - Level reads pins, writes go to latch
// - Missing bits disabled and read zero
// - Open-drain bit: drive low, release high
// - Analog config resets zero, pins analog
// - Analog pins read zero on level
// - Analog pin set output still drives
// - Bit operations read pins, not latch
// - Enabled notify change raises interrupt request
// - Change detect works with clocks stopped
// - Per-input notify enables in two registers
// - Per-input pull-up enables in two registers
// - Converter off makes analog pins digital
`timescale 1ns/1ps
`default_nettype none

module gpc_port #(
    parameter int NUM_PINS = gpc_pkg::GPC_PINS_MAX,
    parameter int NUM_CN = gpc_pkg::GPC_CN_MAX,
    parameter logic [gpc_pkg::GPC_HALF_W-1:0] IMPL_MASK = gpc_pkg::GPC_IMPL_DFLT,
    parameter logic [gpc_pkg::GPC_HALF_W-1:0] ANALOG_CAP = gpc_pkg::GPC_ANCAP_DFLT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gpc_pkg::GPC_ADDR_W-1:0] paddr,
    input wire logic [gpc_pkg::GPC_DATA_W-1:0] pwdata,
    output logic [gpc_pkg::GPC_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port pins
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe_n,
    // Shared peripherals
    input wire logic [NUM_PINS-1:0] periph_enable,
    input wire logic [NUM_PINS-1:0] periph_drive,
    input wire logic [NUM_PINS-1:0] periph_out,
    output logic [NUM_PINS-1:0] periph_in,
    // Converter
    input wire logic converter_disable,
    output logic [NUM_PINS-1:0] analog_sel,
    // Change notification
    input wire logic [NUM_CN-1:0] change_notify_input,
    output logic [NUM_CN-1:0] cn_pullup_en,
    output logic cn_irq,
    output logic cn_wake
);
    import gpc_pkg::*;

    localparam logic [NUM_PINS-1:0] IMPL = IMPL_MASK[NUM_PINS-1:0];
    localparam logic [NUM_PINS-1:0] ANCAP = ANALOG_CAP[NUM_PINS-1:0] & IMPL;
    localparam logic [GPC_DATA_W-1:0] CN_MASK = (32'h1 << NUM_CN) - 32'h1;

    // ==========================================================
    // Elaboration checks
    generate
        if (NUM_PINS < 1 || NUM_PINS > GPC_PINS_MAX)
        begin : g_bad_pins
            $error("NUM_PINS out of range");
        end
        if (NUM_CN < 1 || NUM_CN > GPC_CN_MAX)
        begin : g_bad_cn
            $error("NUM_CN out of range");
        end
    endgenerate

    // ==========================================================
    // Declarations
    logic [NUM_PINS-1:0] dir_r;
    logic [NUM_PINS-1:0] latch_r;
    logic [NUM_PINS-1:0] odc_r;
    logic [NUM_PINS-1:0] ancfg_r;
    logic [GPC_HALF_W-1:0] cnen_lo_r;
    logic [GPC_HALF_W-1:0] cnen_hi_r;
    logic [GPC_HALF_W-1:0] cnpu_lo_r;
    logic [GPC_HALF_W-1:0] cnpu_hi_r;
    logic [NUM_PINS-1:0] ps1_r;
    logic [NUM_PINS-1:0] ps2_r;
    logic [NUM_PINS-1:0] ps3_r;
    logic [NUM_PINS-1:0] pfilt_r;
    logic [GPC_DATA_W-1:0] prdata_r;
    logic pslverr_r;
    logic [NUM_PINS-1:0] pin_out_r;
    logic [NUM_PINS-1:0] pin_oe_n_r;
    logic [NUM_PINS-1:0] periph_in_r;
    logic [NUM_PINS-1:0] analog_sel_r;
    logic [NUM_PINS-1:0] own_w;
    logic [NUM_PINS-1:0] port_drv_w;
    logic [NUM_PINS-1:0] analog_w;
    logic [NUM_PINS-1:0] level_w;
    logic [NUM_PINS-1:0] oe_n_nxt;
    logic [NUM_PINS-1:0] out_nxt;
    logic [NUM_PINS-1:0] wdata_pins;
    logic [GPC_DATA_W-1:0] cn_en_all;
    logic [GPC_DATA_W-1:0] cn_pu_all;
    logic [GPC_DATA_W-1:0] rd_data;
    logic rd_ok;
    logic wr_acc;
    logic setup;

    gpc_cn_if #(.N(NUM_CN)) cn_bus ();

    // ==========================================================
    // APB strobes: zero wait states, write lands in the access cycle
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign wdata_pins = pwdata[NUM_PINS-1:0];
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // Direction register; missing bits held at zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dir_r <= DIR_RST[NUM_PINS-1:0] & IMPL;
        else if (wr_acc && paddr == OFS_PIN_DIRECTION)
            dir_r <= wdata_pins & IMPL;
    end

    // Output latch: written through either the latch or the level offset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            latch_r <= LATCH_RST[NUM_PINS-1:0];
        else if (wr_acc && (paddr == OFS_OUTPUT_LATCH || paddr == OFS_PIN_LEVEL))
            latch_r <= wdata_pins & IMPL;
    end

    // Open-drain select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            odc_r <= ODC_RST[NUM_PINS-1:0];
        else if (wr_acc && paddr == OFS_OPEN_DRAIN)
            odc_r <= wdata_pins & IMPL;
    end

    // Analog config: zero means analog, only capable pins hold a bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ancfg_r <= ANCFG_RST[NUM_PINS-1:0];
        else if (wr_acc && paddr == OFS_ANALOG_CFG)
            ancfg_r <= wdata_pins & ANCAP;
    end

    // Change-notify enables, split over two words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnen_lo_r <= CNEN_RST;
            cnen_hi_r <= CNEN_RST;
        end
        else if (wr_acc && paddr == OFS_CN_ENABLE_LO)
            cnen_lo_r <= pwdata[GPC_HALF_W-1:0] & CN_MASK[GPC_HALF_W-1:0];
        else if (wr_acc && paddr == OFS_CN_ENABLE_HI)
            cnen_hi_r <= pwdata[GPC_HALF_W-1:0] & CN_MASK[GPC_DATA_W-1:GPC_HALF_W];
    end

    // Weak pull-up enables, split over two words
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnpu_lo_r <= CNPU_RST;
            cnpu_hi_r <= CNPU_RST;
        end
        else if (wr_acc && paddr == OFS_PULLUP_LO)
            cnpu_lo_r <= pwdata[GPC_HALF_W-1:0] & CN_MASK[GPC_HALF_W-1:0];
        else if (wr_acc && paddr == OFS_PULLUP_HI)
            cnpu_hi_r <= pwdata[GPC_HALF_W-1:0] & CN_MASK[GPC_DATA_W-1:GPC_HALF_W];
    end

    assign cn_en_all = {cnen_hi_r, cnen_lo_r};
    assign cn_pu_all = {cnpu_hi_r, cnpu_lo_r};
    assign cn_pullup_en = cn_pu_all[NUM_CN-1:0];

    // ==========================================================
    // Pin synchroniser: ps1 feeds only ps2
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps1_r <= '0;
            ps2_r <= '0;
            ps3_r <= '0;
        end
        else
        begin
            ps1_r <= pin_in;
            ps2_r <= ps1_r;
            ps3_r <= ps2_r;
        end
    end

    // Level follows once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pfilt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    pfilt_r[g] <= 1'b0;
                else if (ps2_r[g] == ps3_r[g])
                    pfilt_r[g] <= ps3_r[g];
            end
        end
    endgenerate

    // ==========================================================
    // Pin ownership and modes
    // Converter off forces capable pins to digital
    assign analog_w = ANCAP & ~ancfg_r & {NUM_PINS{!converter_disable}};
    assign own_w = periph_enable & periph_drive & IMPL;
    // Analog mode does not gate the driver, so output-set analog pins still drive
    assign port_drv_w = ~dir_r & IMPL & ~own_w;
    // Digital input buffer is off on analog pins, so they read low
    assign level_w = pfilt_r & ~analog_w & IMPL;

    // Driver select; open drain only pulls low on port-driven pins, a driving peripheral ignores it
    always_comb
    begin
        out_nxt = own_w & periph_out | ~own_w & latch_r;
        oe_n_nxt = ~(own_w | port_drv_w & ~(odc_r & latch_r));
    end

    // Registered pad and peripheral outputs; missing pins stay released
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_r <= '0;
            pin_oe_n_r <= '1;
            periph_in_r <= '0;
            analog_sel_r <= '0;
        end
        else
        begin
            pin_out_r <= out_nxt & IMPL;
            pin_oe_n_r <= oe_n_nxt | ~IMPL;
            periph_in_r <= level_w & ~port_drv_w;
            analog_sel_r <= analog_w;
        end
    end

    assign pin_out = pin_out_r;
    assign pin_oe_n = pin_oe_n_r;
    assign periph_in = periph_in_r;
    assign analog_sel = analog_sel_r;

    // ==========================================================
    // Change-notify hookup
    assign cn_bus.raw = change_notify_input;
    assign cn_bus.enable = cn_en_all[NUM_CN-1:0];
    assign cn_bus.clear = wr_acc && paddr == OFS_CN_STATUS && pwdata[CN_PEND_BIT];
    assign cn_irq = cn_bus.pending;
    assign cn_wake = cn_bus.wake;

    gpc_cn_detect #(.N(NUM_CN)) u_cn (
        .pclk(pclk),
        .presetn(presetn),
        .cn(cn_bus)
    );

    // ==========================================================
    // Read mux; bit operations on the level word read pins, not latch
    always_comb
    begin
        rd_data = '0;
        rd_ok = 1'b1;
        case (paddr)
            OFS_PIN_DIRECTION: rd_data = GPC_DATA_W'(dir_r);
            OFS_OUTPUT_LATCH: rd_data = GPC_DATA_W'(latch_r);
            OFS_PIN_LEVEL: rd_data = GPC_DATA_W'(level_w);
            OFS_OPEN_DRAIN: rd_data = GPC_DATA_W'(odc_r);
            OFS_ANALOG_CFG: rd_data = GPC_DATA_W'(ancfg_r);
            OFS_CN_ENABLE_LO: rd_data = GPC_DATA_W'(cnen_lo_r);
            OFS_CN_ENABLE_HI: rd_data = GPC_DATA_W'(cnen_hi_r);
            OFS_PULLUP_LO: rd_data = GPC_DATA_W'(cnpu_lo_r);
            OFS_PULLUP_HI: rd_data = GPC_DATA_W'(cnpu_hi_r);
            OFS_CN_STATUS: rd_data = GPC_DATA_W'(cn_bus.pending);
            default: rd_ok = 1'b0;
        endcase
    end

    // Read data and error captured in setup, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
        else if (setup)
        begin
            prdata_r <= pwrite ? '0 : rd_data;
            pslverr_r <= !rd_ok;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_periph_owns_pin: assert property (1'b1 |=>
        ((($past(own_w) & pin_oe_n) == '0) &&
        ((($past(periph_out) ^ pin_out) & $past(own_w)) == '0)))
        else $error("driving peripheral did not own its pin");
    a_port_drives_idle: assert property (1'b1 |=>
        (($past(periph_enable & ~periph_drive & ~dir_r & ~odc_r & IMPL) &
        (pin_oe_n | (pin_out ^ $past(latch_r)))) == '0))
        else $error("port did not drive a pin its peripheral left idle");
    a_input_released: assert property (1'b1 |=>
        (($past(dir_r & ~own_w) & ~pin_oe_n) == '0))
        else $error("input pin was driven");
    a_no_loop_through: assert property (1'b1 |=>
        (($past(port_drv_w) & periph_in) == '0))
        else $error("port output reached peripheral input");
    a_dir_reset: assert property ($rose(presetn) |->
        dir_r == (DIR_RST[NUM_PINS-1:0] & IMPL))
        else $error("direction not all inputs after reset");
    a_analog_reset: assert property ($rose(presetn) |-> ancfg_r == '0)
        else $error("analog config not zero after reset");
    a_level_write: assert property (wr_acc && paddr == OFS_PIN_LEVEL |=>
        latch_r == ($past(wdata_pins) & IMPL))
        else $error("level write did not reach the latch");
    a_level_read: assert property (setup && !pwrite && paddr == OFS_PIN_LEVEL |=>
        prdata_r == GPC_DATA_W'($past(pfilt_r & ~analog_w & IMPL)))
        else $error("level read wrong");
    a_open_drain_low: assert property (1'b1 |=>
        (($past(odc_r & ~own_w) & ~pin_oe_n & pin_out) == '0))
        else $error("open-drain pin driven high");
    a_converter_off: assert property (converter_disable |=> analog_sel == '0)
        else $error("analog mode while converter off");

endmodule

`default_nettype wire

// ===== testbench/gpc_pin_model.sv
/* Pad model: resolves each pad from the port driver, an outside source or a toggling float value.
   Assumes ext_en marks pads that an outside source holds. */
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_model (
    // Clock
    input wire logic pclk,
    // Port side
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    // Outside source
    input wire logic [15:0] ext_val,
    input wire logic [15:0] ext_en,
    output logic [15:0] pin_in
);
    // ==========================================================
    // Floating pads toggle every cycle, so the pin filter never accepts them and holds its last agreed level
    logic [15:0] float_r = 16'h5a5a;
    always @(posedge pclk)
        float_r <= ~float_r;
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
        | (pin_oe_n & ~ext_en & float_r);
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
/* Self-checking bench for gpc_port over APB.
   Assumes gpc_pin_model closes the pad loop; bit 15 left unimplemented. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import gpc_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, conv_off = 1'h0, cn_irq, cn_wake;
    logic [15:0] pin_in, pin_out, pin_oe_n, p_in, an;
    logic [15:0] pen = 16'h0, pdrv = 16'h0, pout = 16'h0;
    logic [30:0] cn_in = 31'h0, cn_pu;
    int errors = 0, check_count = 0;
    always #25 pclk = ~pclk;
    gpc_port #(.IMPL_MASK(16'h7fff)) gpc_port_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_enable(pen), .periph_drive(pdrv),
        .periph_out(pout), .periph_in(p_in), .converter_disable(conv_off),
        .analog_sel(an), .change_notify_input(cn_in), .cn_pullup_en(cn_pu),
        .cn_irq(cn_irq), .cn_wake(cn_wake));
    gpc_pin_model gpc_pin_model_i (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .ext_val(16'h0f0f), .ext_en(16'h7fff), .pin_in(pin_in));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (n >= 20)
        begin
            errors++;
            end_sim();
        end
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        idle(2);
        chk({16'h0, pin_oe_n}, 32'hffff);
        chk({16'h0, an}, 32'h003f);
        apb(1'h0, OFS_PIN_DIRECTION, 32'h0);
        chk(rd, 32'h7fff);
        apb(1'h0, OFS_ANALOG_CFG, 32'h0);
        chk(rd, 32'h0);
        // Analog pins kept as inputs, outside source on every pad except bit 15
        apb(1'h0, OFS_PIN_LEVEL, 32'h0);
        chk(rd, 32'h0f00);
        apb(1'h0, 8'h3c, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_latch();
        apb(1'h1, OFS_PIN_DIRECTION, 32'h0);
        apb(1'h1, OFS_OUTPUT_LATCH, 32'ha5a5);
        idle(8);
        chk({16'h0, pin_oe_n}, 32'h8000);
        chk({16'h0, pin_out & 16'h7fff}, 32'h25a5);
        apb(1'h0, OFS_OUTPUT_LATCH, 32'h0);
        chk(rd, 32'h25a5);
        apb(1'h0, OFS_PIN_LEVEL, 32'h0);
        chk(rd, 32'h2580);
        chk({16'h0, p_in}, 32'h0);
        apb(1'h1, OFS_PIN_LEVEL, 32'h3c3c);
        apb(1'h0, OFS_OUTPUT_LATCH, 32'h0);
        chk(rd, 32'h3c3c);
        conv_off <= 1'h1;
        idle(8);
        chk({16'h0, an}, 32'h0);
        apb(1'h0, OFS_PIN_LEVEL, 32'h0);
        chk(rd, 32'h3c3c);
        conv_off <= 1'h0;
        $display("test latch done");
    endtask
    task automatic t_drive();
        apb(1'h1, OFS_OPEN_DRAIN, 32'hffff);
        // Long enough for released pads to pass the pin synchroniser
        idle(4);
        chk({16'h0, pin_oe_n}, 32'hbc3c);
        // Released pads show the outside level, so pins differ from latch
        apb(1'h0, OFS_PIN_LEVEL, 32'h0);
        chk(rd, 32'h0c00);
        apb(1'h1, OFS_OPEN_DRAIN, 32'h0);
        pen <= 16'h0001;
        pdrv <= 16'h0001;
        pout <= 16'h0001;
        idle(3);
        chk({30'h0, pin_out[0], pin_oe_n[0]}, 32'h2);
        pdrv <= 16'h0;
        idle(3);
        chk({30'h0, pin_out[0], pin_oe_n[0]}, 32'h0);
        $display("test drive done");
    endtask
    task automatic t_notify();
        int n;
        cn_in <= 31'h2;
        idle(10);
        chk({31'h0, cn_irq}, 32'h0);
        apb(1'h1, OFS_CN_ENABLE_HI, 32'h4000);
        cn_in <= 31'h40000002;
        @(posedge pclk);
        chk({31'h0, cn_wake}, 32'h1);
        n = 0;
        while (cn_irq !== 1'h1 && n < 12)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, cn_irq}, 32'h1);
        apb(1'h0, OFS_CN_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, cn_wake}, 32'h0);
        apb(1'h1, OFS_CN_STATUS, 32'h1);
        idle(2);
        chk({31'h0, cn_irq}, 32'h0);
        // Pads back to inputs before any pull-up is switched on
        apb(1'h1, OFS_PIN_DIRECTION, 32'hffff);
        apb(1'h1, OFS_PULLUP_LO, 32'h1);
        apb(1'h1, OFS_PULLUP_HI, 32'h4000);
        idle(2);
        chk({1'h0, cn_pu}, 32'h40000001);
        $display("test notify done");
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        idle(10);
        presetn <= 1'h1;
        t_reset();
        t_latch();
        t_drive();
        t_notify();
        end_sim();
    end
endmodule
`default_nettype wire
